// ==== host_clk_model.sv ====
// host side: makes the mic clock, idle low when stopped
// assumes the bench picks a half period in ns
`timescale 1ns/100ps
`default_nettype none
module host_clk_model (
  input wire logic run_i,
  input wire logic auto_i,
  input wire logic wake_i,
  input wire logic [15:0] half_ns_i,
  output var logic mic_clk_o
);
  wire go = run_i || (auto_i && wake_i); // host starts clock on wake
  // clock runs only while asked; band set by half period
  initial begin
    mic_clk_o = 1'b0;
    forever begin
      if (go) begin
        #(half_ns_i) mic_clk_o = ~mic_clk_o;
      end else begin
        mic_clk_o = 1'b0;
        @(posedge go);
      end
    end
  end
endmodule
`default_nettype wire

// ==== level_tracker.v ====
// rectifier, low-pass averager and threshold comparator for sound level
// assumes a signed level sample with a one-cycle strobe, same clock domain
`timescale 1ns/100ps
`default_nettype none
module level_tracker (
  input wire ref_clk_i,
  input wire rstn_i,
  input wire sample_vld_i,
  input wire signed [15:0] sample_i,
  input wire [4:0] avg_shift_i,
  output reg above_o,
  output reg [3:0] amp_gain_setting_o
);
  // rectified sample
  wire [15:0] mag = sample_i[15] ? (~sample_i + 16'h0001) : sample_i;
  // long-term average held with 26 fraction bits
  reg [41:0] avg_reg;
  wire [41:0] mag_w = {mag, 26'h0000000};
  wire [41:0] delta = (mag_w >= avg_reg) ? ((mag_w - avg_reg) >> avg_shift_i)
                                         : ((avg_reg - mag_w) >> avg_shift_i);
  wire [15:0] avg_int = avg_reg[41:26];
  // threshold sits at three times the averaged background plus 16
  wire [17:0] thresh = {2'b00, avg_int} + {1'b0, avg_int, 1'b0} + 18'h00010;
  // ------------------------------------------------------------
  // averaging, comparison and gain steering
  // ------------------------------------------------------------
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      avg_reg <= 42'h0;
      above_o <= 1'b0;
      amp_gain_setting_o <= 4'h0;
    end else if (sample_vld_i) begin
      // rectify and low-pass the level
      if (mag_w >= avg_reg) begin
        avg_reg <= avg_reg + delta;
      end else begin
        avg_reg <= avg_reg - delta;
      end
      // over threshold sets, under clears
      above_o <= ({2'b00, mag} > thresh);
      // quieter background means more gain
      if (avg_int[15:12] != 4'h0) begin
        amp_gain_setting_o <= 4'h0;
      end else if (avg_int[11:8] != 4'h0) begin
        amp_gain_setting_o <= 4'h4;
      end else if (avg_int[7:4] != 4'h0) begin
        amp_gain_setting_o <= 4'h8;
      end else begin
        amp_gain_setting_o <= 4'hf;
      end
    end
  end
endmodule
`default_nettype wire

// ==== mic_mode_ctrl.v ====
// clock-rate mode selection, wake flag path and pdm data line driver
// assumes mic clock and channel select are asynchronous pins, and that
// the sound level and modulator bit arrive from logic on ref_clk_i
`include "mic_mode_defs.vh"
`timescale 1ns/100ps
`default_nettype none
// What this block does
// R01 - no clock means low-power listening mode
// R02 - wake pin flags level above threshold
// R03 - threshold follows background noise level
// R04 - rectify, average 1Hz/2Hz, steer gain
// R05 - fast convergence first second, then slow
// R06 - wake output blanked first second
// R07 - valid clock enters streaming, even at power-up
// R08 - streaming needs no prior wake flag
// R09 - wake path keeps running while streaming
// R10 - anti-pop alternating pattern, then audio
// R11 - stream settled within 200 us
// R12 - host starts clock on wake flag
// R13 - left: drive after fall, release after rise
// R14 - right: drive after rise, release after fall
// R15 - clock under 250 kHz gives standby (here only down to 125 kHz; slower clocks time out to listen)
// R16 - clock bands select low or full power
// R17 - channel select picks launch edge
// R18 - classify by reference, timeout to listen
// R19 - flag drops when level falls below
module mic_mode_ctrl #(
  parameter BLANK_CYCLES = `BLANK_CYCLES,
  parameter CONVERGE_CYCLES = `CONVERGE_CYCLES
) (
  input wire ref_clk_i,
  input wire rstn_i,
  input wire mic_clk_i,
  input wire chan_sel_i,
  input wire filter_corner_select_i,
  input wire level_vld_i,
  input wire signed [15:0] level_i,
  input wire pdm_bit_i,
  output reg sound_wake_o,
  output wire [3:0] amp_gain_setting_o,
  output reg pdm_data_o,
  output reg pdm_data_oe_o,
  output wire [1:0] mode_o,
  output wire settled_o
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  reg clk_s1_reg;
  reg clk_s2_reg;
  reg clk_s3_reg;
  reg sel_s1_reg;
  reg sel_s2_reg;
  // two flops per pin, third flop only for edge finding
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clk_s1_reg <= 1'b0;
      clk_s2_reg <= 1'b0;
      clk_s3_reg <= 1'b0;
      sel_s1_reg <= 1'b0;
      sel_s2_reg <= 1'b0;
    end else begin
      clk_s1_reg <= mic_clk_i;
      clk_s2_reg <= clk_s1_reg;
      clk_s3_reg <= clk_s2_reg;
      sel_s1_reg <= chan_sel_i;
      sel_s2_reg <= sel_s1_reg;
    end
  end
  wire clk_rise = clk_s2_reg & ~clk_s3_reg;
  wire clk_fall = ~clk_s2_reg & clk_s3_reg;

  // ------------------------------------------------------------
  // clock period measurement and mode choice
  // ------------------------------------------------------------
  reg [11:0] per_cnt_reg;
  reg [1:0] mode_reg;
  reg [1:0] mode_next;
  reg [1:0] cand_reg;
  // band of the period just measured
  reg [1:0] band;
  always @* begin
    band = `MODE_STANDBY;
    if (per_cnt_reg <= `FP_MAX_CYCLES) begin
      band = `MODE_FULLPWR; // see R16
    end else if (per_cnt_reg >= `LP_MIN_CYCLES && per_cnt_reg <= `LP_MAX_CYCLES) begin
      band = `MODE_LOWPWR; // see R16
    end else if (per_cnt_reg >= `STBY_CYCLES) begin
      band = `MODE_STANDBY; // see R15
    end else begin
      band = mode_reg; // guard bands keep the present mode
    end
  end
  // mode changes when two periods in a row agree, or to listen on clock timeout
  always @* begin
    mode_next = mode_reg;
    if (per_cnt_reg >= `CLK_LOSS_CYCLES) begin
      mode_next = `MODE_LISTEN; // see R01, R18
    end else if (clk_rise && band == cand_reg) begin
      mode_next = band; // see R07, R08, R18
    end
  end
  // period counter runs between rising edges, saturating at the timeout
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      per_cnt_reg <= 12'hfff;
      mode_reg <= `MODE_LISTEN; // see R01
      cand_reg <= `MODE_LISTEN;
    end else begin
      mode_reg <= mode_next;
      if (clk_rise) begin
        per_cnt_reg <= 12'h001;
        cand_reg <= band;
      end else if (per_cnt_reg < `CLK_LOSS_CYCLES) begin
        per_cnt_reg <= per_cnt_reg + 12'h001;
      end
    end
  end
  assign mode_o = mode_reg;
  wire streaming = (mode_reg == `MODE_LOWPWR) || (mode_reg == `MODE_FULLPWR);

  // ------------------------------------------------------------
  // power-up timers: blanking and fast convergence
  // ------------------------------------------------------------
  reg [27:0] up_cnt_reg;
  wire blank_done = (up_cnt_reg >= BLANK_CYCLES);
  wire conv_done = (up_cnt_reg >= CONVERGE_CYCLES);
  // counts once from reset release, then holds
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      up_cnt_reg <= 28'h0;
    end else if (!(blank_done && conv_done)) begin
      up_cnt_reg <= up_cnt_reg + 28'h1;
    end
  end

  // ------------------------------------------------------------
  // sound level tracking and wake flag
  // ------------------------------------------------------------
  wire above;
  // fast rate first, then the selected corner
  wire [4:0] avg_shift = !conv_done ? `AVG_SHIFT_FAST : // see R05
                         (filter_corner_select_i ? `AVG_SHIFT_2HZ : `AVG_SHIFT_1HZ); // see R04
  // tracker runs in every mode, streaming included
  level_tracker u_level (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .sample_vld_i(level_vld_i), // see R09
    .sample_i(level_i),
    .avg_shift_i(avg_shift),
    .above_o(above), // see R03
    .amp_gain_setting_o(amp_gain_setting_o) // see R04
  );
  // wake flag, held low while blanking; standby carries no flag
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sound_wake_o <= 1'b0;
    end else if (!blank_done) begin
      sound_wake_o <= 1'b0; // see R06
    end else if (mode_reg == `MODE_STANDBY) begin
      sound_wake_o <= 1'b0;
    end else begin
      sound_wake_o <= above; // see R02, R19
    end
  end

  // ------------------------------------------------------------
  // stream start: anti-pop pattern then audio, settle flag
  // ------------------------------------------------------------
  reg [15:0] start_cnt_reg;
  reg pop_bit_reg;
  wire in_pop = (start_cnt_reg < `POP_CYCLES);
  // counts from entry into a streaming mode
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      start_cnt_reg <= 16'h0;
      pop_bit_reg <= 1'b0;
    end else if (!streaming) begin
      start_cnt_reg <= 16'h0;
      pop_bit_reg <= 1'b0;
    end else begin
      if (start_cnt_reg < `SETTLE_CYCLES) begin
        start_cnt_reg <= start_cnt_reg + 16'h1;
      end
      // alternate once per launched bit for 50 percent density
      if ((sel_s2_reg && clk_rise) || (!sel_s2_reg && clk_fall)) begin
        pop_bit_reg <= ~pop_bit_reg; // see R10
      end
    end
  end
  assign settled_o = streaming && (start_cnt_reg >= `SETTLE_CYCLES); // see R11

  // ------------------------------------------------------------
  // shared data line driver
  // ------------------------------------------------------------
  // launch edge and release edge follow the channel select
  wire launch = sel_s2_reg ? clk_rise : clk_fall; // see R17
  wire release_edge = sel_s2_reg ? clk_fall : clk_rise;
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pdm_data_o <= 1'b0;
      pdm_data_oe_o <= 1'b0;
    end else if (!streaming) begin
      pdm_data_o <= 1'b0; // listen and standby leave the line free
      pdm_data_oe_o <= 1'b0;
    end else if (launch) begin
      pdm_data_o <= in_pop ? pop_bit_reg : pdm_bit_i; // see R10
      pdm_data_oe_o <= 1'b1; // see R13, R14
    end else if (release_edge) begin
      pdm_data_oe_o <= 1'b0; // see R13, R14
    end
  end
  // the host reacts to the wake flag by starting the clock (see R12)
endmodule
`default_nettype wire

// ==== mic_mode_defs.vh ====
// timing counts and mode codes for the microphone mode controller
// assumes a 200 MHz reference clock; counts derive from times in ns/us
`ifndef MIC_MODE_DEFS_VH
`define MIC_MODE_DEFS_VH
// reference clock period in ns
`define REF_PERIOD_NS 5
// power-up blanking of the wake flag, in us
`define BLANK_TIME_US 1000000
`define BLANK_CYCLES (`BLANK_TIME_US * 1000 / `REF_PERIOD_NS)
// fast convergence window after power-up, in us
`define CONVERGE_TIME_US 1000000
`define CONVERGE_CYCLES (`CONVERGE_TIME_US * 1000 / `REF_PERIOD_NS)
// anti-pop alternating pattern span, in us (must start within 50 us)
`define POP_TIME_US 50
`define POP_CYCLES (`POP_TIME_US * 1000 / `REF_PERIOD_NS)
// settle time to nominal sensitivity, in us
`define SETTLE_TIME_US 200
`define SETTLE_CYCLES (`SETTLE_TIME_US * 1000 / `REF_PERIOD_NS)
// band edges as clock period in ns: 250 kHz = 4000 ns, 350 kHz ~ 2857 ns,
// 900 kHz ~ 1111 ns, 1.1 MHz ~ 909 ns; longest valid period 8000 ns
`define STBY_PERIOD_NS 4000
`define LP_MAX_PERIOD_NS 2857
`define LP_MIN_PERIOD_NS 1112
`define FP_MAX_PERIOD_NS 909
`define STBY_CYCLES (`STBY_PERIOD_NS / `REF_PERIOD_NS)
`define LP_MAX_CYCLES (`LP_MAX_PERIOD_NS / `REF_PERIOD_NS)
`define LP_MIN_CYCLES ((`LP_MIN_PERIOD_NS + `REF_PERIOD_NS - 1) / `REF_PERIOD_NS)
`define FP_MAX_CYCLES (`FP_MAX_PERIOD_NS / `REF_PERIOD_NS)
// no edge for longer than the slowest valid period means clock stopped
`define CLK_LOSS_NS 8000
`define CLK_LOSS_CYCLES (`CLK_LOSS_NS / `REF_PERIOD_NS)
// modes
`define MODE_LISTEN 2'd0
`define MODE_STANDBY 2'd1
`define MODE_LOWPWR 2'd2
`define MODE_FULLPWR 2'd3
// level averager shifts for the fast rate and the two corners (fast, 1 Hz, 2 Hz)
`define AVG_SHIFT_FAST 5'd12
`define AVG_SHIFT_1HZ 5'd26
`define AVG_SHIFT_2HZ 5'd25
`endif

// ==== mic_mode_monitor.sv ====
// concurrent checks on the mode controller ports
// assumes blanking parameter matches the bound design instance
`timescale 1ns/100ps
`default_nettype none
module mic_mode_monitor #(
  parameter BLANK_CYCLES = 2000
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic mic_clk_i,
  input wire logic chan_sel_i,
  input wire logic filter_corner_select_i,
  input wire logic level_vld_i,
  input wire logic signed [15:0] level_i,
  input wire logic pdm_bit_i,
  input wire logic sound_wake_o,
  input wire logic [3:0] amp_gain_setting_o,
  input wire logic pdm_data_o,
  input wire logic pdm_data_oe_o,
  input wire logic [1:0] mode_o,
  input wire logic settled_o
);
  // ----------------------------------------
  // helper counters
  // ----------------------------------------
  reg [31:0] up_cnt_reg; // cycles since reset, saturating
  reg [11:0] idle_cnt_reg; // cycles since last mic clock rise
  reg clk_d_reg; // previous sampled mic clock
  // count age and clock idle time
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      up_cnt_reg <= 32'h0;
      idle_cnt_reg <= 12'h0;
      clk_d_reg <= 1'b0;
    end else begin
      clk_d_reg <= mic_clk_i;
      if (up_cnt_reg < BLANK_CYCLES) up_cnt_reg <= up_cnt_reg + 32'h1;
      if (mic_clk_i && !clk_d_reg) idle_cnt_reg <= 12'h0;
      else if (idle_cnt_reg != 12'hfff) idle_cnt_reg <= idle_cnt_reg + 12'h1;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_wake_blanked: assert property (up_cnt_reg < BLANK_CYCLES - 2 |-> !sound_wake_o)
    else $error("wake flag during blanking");
  a_wake_raised: assert property (level_vld_i && level_i == 16'sh7fff
    && up_cnt_reg >= BLANK_CYCLES && mode_o != 2'h1 ##1 !level_vld_i
    |-> ##1 (sound_wake_o || mode_o == 2'h1)) else $error("loud sample gave no wake");
  a_wake_cleared: assert property (level_vld_i && level_i == 16'sh0000
    ##1 !level_vld_i |-> ##1 !sound_wake_o) else $error("quiet sample kept wake");
  a_standby_silent: assert property (mode_o == 2'h1 && $past(mode_o) == 2'h1
    |-> !sound_wake_o && !pdm_data_oe_o) else $error("standby not silent");
  a_listen_silent: assert property (mode_o == 2'h0 && $past(mode_o) == 2'h0
    |-> !pdm_data_oe_o) else $error("line driven in listen");
  a_clock_lost: assert property (idle_cnt_reg == 12'd1620 |-> mode_o == 2'h0)
    else $error("no listen after clock loss");
  a_left_launch: assert property ($rose(pdm_data_oe_o) && !chan_sel_i |-> !mic_clk_i)
    else $error("left drive not after fall");
  a_right_launch: assert property ($rose(pdm_data_oe_o) && chan_sel_i |-> mic_clk_i)
    else $error("right drive not after rise");
  a_left_release: assert property ($fell(pdm_data_oe_o) && !chan_sel_i && mode_o[1]
    |-> mic_clk_i) else $error("left release not after rise");
endmodule
bind mic_mode_ctrl mic_mode_monitor #(.BLANK_CYCLES(BLANK_CYCLES)) mon_u (
  .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .mic_clk_i(mic_clk_i), .chan_sel_i(chan_sel_i),
  .filter_corner_select_i(filter_corner_select_i), .level_vld_i(level_vld_i),
  .level_i(level_i), .pdm_bit_i(pdm_bit_i), .sound_wake_o(sound_wake_o),
  .amp_gain_setting_o(amp_gain_setting_o), .pdm_data_o(pdm_data_o),
  .pdm_data_oe_o(pdm_data_oe_o), .mode_o(mode_o), .settled_o(settled_o));
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the mode controller
// assumes blanking shortened to 2000 cycles
`timescale 1ns/100ps
`default_nettype none
`define chk(a, b) begin n_tests = n_tests + 1; if ((a) !== (b)) begin \
  bad_count = bad_count + 1; $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
  logic clk = 0, rstn = 0, run = 0, aut = 0, csel = 0, fsel = 0, vld = 0, pbit = 1;
  logic signed [15:0] lvl = 0;
  logic [15:0] half = 16'd250;
  logic mclk, wake, pd, oe, stl, prev;
  logic [3:0] gain;
  logic [1:0] mode;
  integer bad_count = 0, n_tests = 0, i;
  int half_tab[4] = '{250, 800, 2500, 400};
  logic [1:0] mode_tab[4] = '{2'h3, 2'h2, 2'h1, 2'h3};
  host_clk_model host_u (.run_i(run), .auto_i(aut), .wake_i(wake), .half_ns_i(half),
    .mic_clk_o(mclk));
  mic_mode_ctrl #(.BLANK_CYCLES(2000), .CONVERGE_CYCLES(2000)) dut_u (
    .ref_clk_i(clk), .rstn_i(rstn), .mic_clk_i(mclk), .chan_sel_i(csel),
    .filter_corner_select_i(fsel), .level_vld_i(vld), .level_i(lvl), .pdm_bit_i(pbit),
    .sound_wake_o(wake), .amp_gain_setting_o(gain), .pdm_data_o(pd), .pdm_data_oe_o(oe),
    .mode_o(mode), .settled_o(stl));
  // ----------------------------------------
  // clock, watchdog and helpers
  // ----------------------------------------
  initial begin
    forever #2.5 clk = ~clk;
  end
  initial begin
    #450000;
    bad_count = bad_count + 1;
    test_done;
  end
  task tick(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one level strobe, flag read two cycles on
  task send(input logic signed [15:0] v);
    lvl = v;
    vld = 1;
    tick(1);
    vld = 0;
    tick(2);
  endtask
  // wait for the next rise of the drive enable
  task launch;
    integer k;
    k = 0;
    while (oe !== 1'b0 && k < 4000) begin tick(1); k = k + 1; end
    while (oe !== 1'b1 && k < 4000) begin tick(1); k = k + 1; end
    if (k >= 4000) bad_count = bad_count + 1;
  endtask
  task test_done;
    if (bad_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    tick(4);
    rstn = 1;
    `chk(mode, 2'h0)
    tick(100);
    send(16'sh7fff);
    `chk(wake, 1'b0)
    tick(2000);
    for (i = 0; i < 8; i = i + 1) send(16'sh0000);
    `chk(gain, 4'hf)
    send(16'sh7fff);
    `chk(wake, 1'b1)
    fsel = 1;
    send(16'sh0000);
    `chk(wake, 1'b0)
    for (i = 0; i < 4; i = i + 1) begin
      half = half_tab[i];
      run = 1;
      tick(12 * half_tab[i] / 5 + 20);
      `chk(mode, mode_tab[i])
      run = 0;
      tick(2200);
      `chk(mode, 2'h0)
    end
    half = 16'd800;
    run = 1;
    launch;
    prev = pd;
    for (i = 0; i < 6; i = i + 1) begin
      launch;
      `chk(pd, ~prev)
      prev = pd;
    end
    tick(10000);
    launch;
    `chk(pd, 1'b1)
    pbit = 0;
    launch;
    `chk(pd, 1'b0)
    `chk(stl, 1'b0)
    send(16'sh7fff);
    `chk(wake, 1'b1)
    send(16'sh0000);
    tick(30000);
    `chk(stl, 1'b1)
    run = 0;
    tick(2200);
    csel = 1;
    half = 16'd250;
    aut = 1;
    send(16'sh7fff);
    tick(1500);
    `chk(mode, 2'h3)
    send(16'sh0000);
    tick(2200);
    `chk(mode, 2'h0)
    test_done;
  end
endmodule
`default_nettype wire
